// ### hw/fclem_pkg.sv
package fclem_pkg;

  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [11:0] FCLEM_OFF_CTRL    = 12'h000;
  localparam logic [11:0] FCLEM_OFF_LIMIT   = 12'h004;
  localparam logic [11:0] FCLEM_OFF_MULT    = 12'h008;
  localparam logic [11:0] FCLEM_OFF_MONSEL  = 12'h00C;
  localparam logic [11:0] FCLEM_OFF_IRQSTAT = 12'h010;
  localparam logic [11:0] FCLEM_OFF_IRQMASK = 12'h014;
  localparam logic [11:0] FCLEM_OFF_ERROR   = 12'h018;
  localparam logic [11:0] FCLEM_OFF_STATUS  = 12'h01C;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int FCLEM_CTRL_USE_LSB     = 0;
  localparam int FCLEM_CTRL_SPD_LSB     = 4;
  localparam int FCLEM_CTRL_RESTART_BIT = 8;
  localparam int FCLEM_MON2_LSB         = 8;
  localparam int FCLEM_IRQ_ALARM_BIT    = 0;
  localparam int FCLEM_IRQ_ROT_BIT      = 1;
  localparam int FCLEM_STAT_ALARM_BIT   = 0;
  localparam int FCLEM_STAT_SPD_LSB     = 4;
  localparam int FCLEM_STAT_EXT_BIT     = 8;

  // ********************************************************
  // ranges and reset values
  // ********************************************************
  localparam logic [31:0] FCLEM_LIMIT_MAX = 32'h4000_0000;
  localparam logic [31:0] FCLEM_LIMIT_RST = 32'h0000_03E8;
  localparam logic [6:0]  FCLEM_PCT_FULL  = 7'h64;
  localparam logic [6:0]  FCLEM_MULT_RST  = 7'h14;
  localparam logic [7:0]  FCLEM_MON_LOAD_ERR = 8'h07;
  localparam logic [7:0]  FCLEM_MON1_RST  = 8'h02;
  localparam logic [7:0]  FCLEM_MON2_RST  = 8'h00;
  localparam logic [3:0]  FCLEM_SPD_EXT   = 4'h1;
  localparam logic [3:0]  FCLEM_SPD_RST   = 4'h0;
  localparam logic [3:0]  FCLEM_USE_OFF   = 4'h0;
  localparam logic [3:0]  FCLEM_USE_RST   = 4'h0;
  localparam logic [15:0] FCLEM_MON_MAX   = 16'h7FFF;
  localparam logic [15:0] FCLEM_MON_MIN   = 16'h8000;

  // ********************************************************
  // carriers
  // ********************************************************
  typedef struct packed {
    logic        valid;
    logic [31:0] pos;
    logic [31:0] speed;
  } fclem_fb_t;

  typedef struct packed {
    logic [15:0] mon1;
    logic [15:0] mon2;
  } fclem_mon_t;

endpackage

// ### hw/fclem_rot_atten.sv
`timescale 1ns/10ps

module fclem_rot_atten (
  // error carried out of the finished rotation
  input  wire logic [31:0] err_in,
  // multiplier in percent, 0 to 100
  input  wire logic [6:0]  mult,
  // error that the next rotation starts with
  output logic [31:0]      err_out
);
  import fclem_pkg::*;

  logic signed [39:0] prod;
  logic signed [39:0] quot;
  logic        [7:0]  keep;

  // keep (100 - m) percent; division truncates toward zero so a
  // small residue decays to exactly zero over a few rotations
  always_comb begin
    keep    = {1'b0, FCLEM_PCT_FULL} - {1'b0, mult};
    prod    = $signed({{8{err_in[31]}}, err_in}) * $signed({32'h0, keep});
    quot    = prod / $signed({33'h0, FCLEM_PCT_FULL});
    err_out = quot[31:0];
  end

endmodule // fclem_rot_atten

// ### hw/fclem_top.sv
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/10ps

module fclem_top (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // feedback from the encoder front ends
  input  wire fclem_pkg::fclem_fb_t  motor_fb,
  input  wire fclem_pkg::fclem_fb_t  load_fb,
  input  wire logic                  rotation_pulse,
  // results
  output logic                       motor_load_overflow_alarm,
  output logic      [31:0]           speed_feedback,
  output logic                       speed_from_external,
  output fclem_pkg::fclem_mon_t      analog_mon,
  output logic                       irq
);
  import fclem_pkg::*;

  // ********************************************************
  // helpers
  // ********************************************************
  function automatic logic [31:0] clamp32(input logic [31:0] v, input logic [31:0] max);
    return (v > max) ? max : v;
  endfunction

  // one count is 0.01 V; beyond the converter range the output pins at full scale
  function automatic logic [15:0] sat16(input logic [31:0] v);
    if ($signed(v) > $signed({16'h0000, FCLEM_MON_MAX}))
      return FCLEM_MON_MAX;
    else if ($signed(v) < $signed({16'hFFFF, FCLEM_MON_MIN}))
      return FCLEM_MON_MIN;
    else
      return v[15:0];
  endfunction

  function automatic logic [15:0] mon_pick(input logic [7:0] sel, input logic [31:0] err);
    return (sel == FCLEM_MON_LOAD_ERR) ? sat16(err) : 16'h0000;
  endfunction

  // ********************************************************
  // state
  // ********************************************************
  logic [3:0]  use_digit_reg;
  logic [3:0]  spd_pend_reg;
  logic [3:0]  spd_act_reg;
  logic [31:0] limit_reg;
  logic [6:0]  mult_reg;
  logic [7:0]  mon1_sel_reg;
  logic [7:0]  mon2_sel_reg;
  logic [1:0]  irq_stat_reg;
  logic [1:0]  irq_mask_reg;
  logic [31:0] motor_pos_reg;
  logic [31:0] load_pos_reg;
  logic [31:0] offset_reg;
  logic [31:0] err_reg;
  logic        alarm_reg;
  logic [31:0] speed_reg;
  logic        ext_sel_reg;
  logic [15:0] mon1_reg;
  logic [15:0] mon2_reg;
  logic        ready_reg;
  logic [31:0] prdata_reg;

  logic        wr_fire;
  logic        access;
  logic        hit;
  logic [31:0] rdata_next;
  logic [31:0] limit_wr;
  logic [31:0] mult_wr;
  logic [31:0] raw_err;
  logic [31:0] eff_err;
  logic [31:0] err_abs;
  logic        alarm_next;
  logic [31:0] carried_err;
  logic        use_ext;
  logic [1:0]  irq_set;
  logic [1:0]  irq_clr;

  // ********************************************************
  // apb slave
  // ********************************************************
  // one wait state so that read data comes from a flip-flop
  assign access  = psel & penable;
  assign pready  = ready_reg;
  assign pslverr = ready_reg & ~hit;
  assign prdata  = prdata_reg;
  assign wr_fire = access & ready_reg & pwrite & hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= access & ~ready_reg;
    end
  end

  always_comb begin
    hit        = 1'b1;
    rdata_next = 32'h0000_0000;
    unique case (paddr)
      FCLEM_OFF_CTRL: begin
        rdata_next[FCLEM_CTRL_USE_LSB +: 4] = use_digit_reg;
        rdata_next[FCLEM_CTRL_SPD_LSB +: 4] = spd_pend_reg;
      end
      FCLEM_OFF_LIMIT:   rdata_next = limit_reg;
      FCLEM_OFF_MULT:    rdata_next[6:0] = mult_reg;
      FCLEM_OFF_MONSEL: begin
        rdata_next[7:0] = mon1_sel_reg;
        rdata_next[FCLEM_MON2_LSB +: 8] = mon2_sel_reg;
      end
      FCLEM_OFF_IRQSTAT: rdata_next[1:0] = irq_stat_reg;
      FCLEM_OFF_IRQMASK: rdata_next[1:0] = irq_mask_reg;
      FCLEM_OFF_ERROR:   rdata_next = err_reg;
      FCLEM_OFF_STATUS: begin
        rdata_next[FCLEM_STAT_ALARM_BIT]    = alarm_reg;
        rdata_next[FCLEM_STAT_SPD_LSB +: 4] = spd_act_reg;
        rdata_next[FCLEM_STAT_EXT_BIT]      = ext_sel_reg;
      end
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (access & ~ready_reg & ~pwrite) begin
      prdata_reg <= rdata_next;
    end
  end

  // ********************************************************
  // setup registers
  // ********************************************************
  // out-of-range writes clamp to the top of the range
  assign limit_wr = clamp32(pwdata, FCLEM_LIMIT_MAX);
  assign mult_wr  = clamp32(pwdata, {25'h0000000, FCLEM_PCT_FULL});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_reg <= FCLEM_LIMIT_RST;
      mult_reg  <= FCLEM_MULT_RST;
    end else if (wr_fire) begin
      if (paddr == FCLEM_OFF_LIMIT)
        limit_reg <= limit_wr;
      if (paddr == FCLEM_OFF_MULT)
        mult_reg <= mult_wr[6:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon1_sel_reg <= FCLEM_MON1_RST;
      mon2_sel_reg <= FCLEM_MON2_RST;
    end else if (wr_fire && paddr == FCLEM_OFF_MONSEL) begin
      mon1_sel_reg <= pwdata[7:0];
      mon2_sel_reg <= pwdata[FCLEM_MON2_LSB +: 8];
    end
  end

  // the pending speed source is copied to the active one only on restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      use_digit_reg <= FCLEM_USE_RST;
      spd_pend_reg  <= FCLEM_SPD_RST;
      spd_act_reg   <= FCLEM_SPD_RST;
    end else if (wr_fire && paddr == FCLEM_OFF_CTRL) begin
      use_digit_reg <= pwdata[FCLEM_CTRL_USE_LSB +: 4];
      spd_pend_reg  <= pwdata[FCLEM_CTRL_SPD_LSB +: 4];
      if (pwdata[FCLEM_CTRL_RESTART_BIT])
        spd_act_reg <= pwdata[FCLEM_CTRL_SPD_LSB +: 4];
    end
  end

  // ********************************************************
  // position capture and error
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_pos_reg <= 32'h0000_0000;
      load_pos_reg  <= 32'h0000_0000;
    end else begin
      if (motor_fb.valid)
        motor_pos_reg <= motor_fb.pos;
      if (load_fb.valid)
        load_pos_reg <= load_fb.pos;
    end
  end

  // counters wrap, so the difference is taken modulo 2^32
  assign raw_err = motor_pos_reg - load_pos_reg;
  assign eff_err = raw_err - offset_reg;

  fclem_rot_atten u_atten (
    .err_in  (eff_err),
    .mult    (mult_reg),
    .err_out (carried_err)
  );

  // at a rotation boundary the offset is moved so that the effective
  // error equals the scaled error; at 0 percent the offset stays put
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_reg <= 32'h0000_0000;
    end else if (rotation_pulse) begin
      offset_reg <= raw_err - carried_err;
    end
  end

  // ********************************************************
  // overflow alarm
  // ********************************************************
  assign err_abs    = eff_err[31] ? (~eff_err + 32'h0000_0001) : eff_err;
  assign alarm_next = (limit_reg != 32'h0000_0000) && (err_abs > limit_reg);

  // evaluated every cycle against the live limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_reg <= 1'b0;
      err_reg   <= 32'h0000_0000;
    end else begin
      alarm_reg <= alarm_next;
      err_reg   <= eff_err;
    end
  end

  assign motor_load_overflow_alarm = alarm_reg;

  // ********************************************************
  // analog monitor
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon1_reg <= 16'h0000;
      mon2_reg <= 16'h0000;
    end else begin
      mon1_reg <= mon_pick(mon1_sel_reg, eff_err);
      mon2_reg <= mon_pick(mon2_sel_reg, eff_err);
    end
  end

  assign analog_mon.mon1 = mon1_reg;
  assign analog_mon.mon2 = mon2_reg;

  // ********************************************************
  // speed feedback
  // ********************************************************
  // without fully-closed operation the external speed is never used
  assign use_ext = (use_digit_reg != FCLEM_USE_OFF) && (spd_act_reg == FCLEM_SPD_EXT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_reg   <= 32'h0000_0000;
      ext_sel_reg <= 1'b0;
    end else begin
      ext_sel_reg <= use_ext;
      speed_reg   <= use_ext ? load_fb.speed : motor_fb.speed;
    end
  end

  assign speed_feedback      = speed_reg;
  assign speed_from_external = ext_sel_reg;

  // ********************************************************
  // interrupts
  // ********************************************************
  assign irq_set[FCLEM_IRQ_ALARM_BIT] = alarm_next & ~alarm_reg;
  assign irq_set[FCLEM_IRQ_ROT_BIT]   = rotation_pulse;
  assign irq_clr = (wr_fire && paddr == FCLEM_OFF_IRQSTAT) ? pwdata[1:0] : 2'h0;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 2'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= 2'h0;
    end else if (wr_fire && paddr == FCLEM_OFF_IRQMASK) begin
      irq_mask_reg <= pwdata[1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule // fclem_top

// ### bench/fclem_top_props.sv
`timescale 1ns/10ps
module fclem_top_props (
  // apb
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // feedback and results
  input wire fclem_pkg::fclem_fb_t motor_fb,
  input wire fclem_pkg::fclem_fb_t load_fb,
  input wire logic                 rotation_pulse,
  input wire logic                 motor_load_overflow_alarm,
  input wire logic [31:0]          speed_feedback,
  input wire logic                 speed_from_external
);
  import fclem_pkg::*;
  logic [31:0] lim, mp, lp, err, mag;
  logic [3:0]  use_d;
  logic        wr, rot_seen, exp_al;
  assign wr = psel & penable & pwrite & pready;
  assign err = mp - lp;
  assign mag = err[31] ? -err : err;
  assign exp_al = (lim != 32'h0) && (mag > lim);
  // ********
  // shadow state
  // ********
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim   <= FCLEM_LIMIT_RST;
      use_d <= 4'h0;
    end else if (wr && paddr == FCLEM_OFF_LIMIT) begin
      lim <= (pwdata > FCLEM_LIMIT_MAX) ? FCLEM_LIMIT_MAX : pwdata;
    end else if (wr && paddr == FCLEM_OFF_CTRL) begin
      use_d <= pwdata[3:0];
    end
  end
  // a rotation moves the hidden offset, so the plain error model holds only until then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mp       <= 32'h0;
      lp       <= 32'h0;
      rot_seen <= 1'h0;
    end else begin
      if (motor_fb.valid) mp <= motor_fb.pos;
      if (load_fb.valid) lp <= load_fb.pos;
      if (rotation_pulse) rot_seen <= 1'h1;
    end
  end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("apb wait state wrong");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
  property p_slverr; pslverr |-> pready && psel && penable; endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr outside access");
  property p_lim0; $past(lim) == 32'h0 |-> !motor_load_overflow_alarm; endproperty
  a_lim0: assert property (p_lim0) else $error("alarm with zero limit");
  property p_alarm; $past(presetn) && !$past(rot_seen) |-> motor_load_overflow_alarm == $past(exp_al); endproperty
  a_alarm: assert property (p_alarm) else $error("alarm differs from error vs limit");
  property p_spd_mot; $past(presetn, 2) && !speed_from_external |-> speed_feedback == $past(motor_fb.speed); endproperty
  a_spd_mot: assert property (p_spd_mot) else $error("motor speed not passed");
  property p_spd_ext; speed_from_external |-> speed_feedback == $past(load_fb.speed); endproperty
  a_spd_ext: assert property (p_spd_ext) else $error("load speed not passed");
  property p_use0; $past(use_d) == 4'h0 |-> !speed_from_external; endproperty
  a_use0: assert property (p_use0) else $error("external speed while usage off");
endmodule // fclem_top_props

bind fclem_top fclem_top_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .motor_fb(motor_fb),
  .load_fb(load_fb), .rotation_pulse(rotation_pulse), .motor_load_overflow_alarm(motor_load_overflow_alarm),
  .speed_feedback(speed_feedback), .speed_from_external(speed_from_external));

// ### bench/fclem_enc_model.sv
`timescale 1ns/10ps
module fclem_enc_model (
  // clock
  input wire logic            pclk,
  // encoder data
  output fclem_pkg::fclem_fb_t motor_fb,
  output fclem_pkg::fclem_fb_t load_fb,
  output logic                rotation_pulse
);
  import fclem_pkg::*;
  logic [31:0] spd;
  initial begin
    motor_fb = '0;
    load_fb = '0;
    rotation_pulse = 1'h0;
    spd = 32'h0;
  end
  // speeds move every cycle so a stale sample shows
  always @(posedge pclk) begin
    spd <= spd + 32'h0000_0101;
    motor_fb.speed <= spd;
    load_fb.speed <= ~spd;
  end
  // positions come already geared, in whole reference units
  task put(input logic [31:0] m, input logic [31:0] l);
    @(posedge pclk);
    motor_fb.valid <= 1'h1;
    motor_fb.pos <= m;
    load_fb.valid <= 1'h1;
    load_fb.pos <= l;
    @(posedge pclk);
    motor_fb.valid <= 1'h0;
    load_fb.valid <= 1'h0;
    // positions are only good with valid
    motor_fb.pos <= ~m;
    load_fb.pos <= ~l;
  endtask
  task rot;
    @(posedge pclk);
    rotation_pulse <= 1'h1;
    @(posedge pclk);
    rotation_pulse <= 1'h0;
  endtask
endmodule // fclem_enc_model

// ### bench/fclem_top_test.sv
`timescale 1ns/10ps
module fclem_top_test;
  import fclem_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, alarm, sfe, irq, rp, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, spd_fb;
  fclem_fb_t   mfb, lfb;
  fclem_mon_t  mon;
  int          num_errors, n_tests;
  logic [31:0] lv [5] = '{32'h1388, 32'h1387, 32'h0, 32'hFFFF_FFFF, 32'h3E8};
  logic [31:0] mv [4] = '{32'h14, 32'h0, 32'h32, 32'h64};
  logic [31:0] me [4] = '{32'hFA0, 32'hFA0, 32'h7D0, 32'h0};
  logic [31:0] cv [3] = '{32'h11, 32'h111, 32'h10};
  fclem_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .motor_fb(mfb),
    .load_fb(lfb), .rotation_pulse(rp), .motor_load_overflow_alarm(alarm), .speed_feedback(spd_fb),
    .speed_from_external(sfe), .analog_mon(mon), .irq(irq));
  fclem_enc_model enc (.pclk(pclk), .motor_fb(mfb), .load_fb(lfb), .rotation_pulse(rp));
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  // ********
  // tasks
  // ********
  task results;
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, x);
    end
  endtask
  // outputs are looked at on the falling edge, where they have settled
  task tick(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  // the request stands until pready is seen high at a rising edge; data and error are taken there
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    tick(1);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(rd, x);
  endtask
  // ********
  // tests
  // ********
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    num_errors = 0;
    n_tests = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    tick(2);
    rdc(FCLEM_OFF_LIMIT, 32'h3E8);
    rdc(FCLEM_OFF_MULT, 32'h14);
    rdc(FCLEM_OFF_MONSEL, 32'h2);
    rdc(FCLEM_OFF_CTRL, 32'h0);
    apb(1'h0, 12'h020, 32'h0);
    chk({31'h0, e}, 32'h1);
    enc.put(32'h1388, 32'h0);
    tick(3);
    chk({31'h0, alarm}, 32'h1);
    rdc(FCLEM_OFF_ERROR, 32'h1388);
    rdc(FCLEM_OFF_IRQSTAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, FCLEM_OFF_IRQMASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, FCLEM_OFF_IRQSTAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'h1, FCLEM_OFF_LIMIT, lv[i]);
      chk({31'h0, alarm}, {31'h0, lv[i] != 32'h0 && 32'h1388 > lv[i]});
      rdc(FCLEM_OFF_LIMIT, (lv[i] > 32'h4000_0000) ? 32'h4000_0000 : lv[i]);
    end
    apb(1'h1, FCLEM_OFF_MONSEL, 32'h0707);
    chk(mon, 32'h1388_1388);
    apb(1'h1, FCLEM_OFF_MONSEL, 32'h2);
    chk(mon, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, FCLEM_OFF_MULT, mv[i]);
      enc.rot;
      tick(3);
      rdc(FCLEM_OFF_ERROR, me[i]);
    end
    rdc(FCLEM_OFF_IRQSTAT, 32'h3);
    apb(1'h1, FCLEM_OFF_MULT, 32'hC8);
    rdc(FCLEM_OFF_MULT, 32'h64);
    // only the middle write restarts and selects the external source; the last one clears the usage digit and switches back
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, FCLEM_OFF_CTRL, cv[i]);
      chk({31'h0, sfe}, {31'h0, i == 1});
    end
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    tick(2);
    rdc(FCLEM_OFF_LIMIT, 32'h3E8);
    chk({31'h0, alarm}, 32'h0);
    results;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    results;
  end
endmodule // fclem_top_test
